// ### fpps_pkg.sv
package fpps_pkg;

  // ----------------------------------------------------------------
  // Fault types
  // ----------------------------------------------------------------
  localparam int FAULT_N = 6;
  localparam int F_TRACK = 0;
  localparam int F_OTEMP = 1;
  localparam int F_OCURR = 2;
  localparam int F_UVOLT = 3;
  localparam int F_OVOLT = 4;
  localparam int F_PHASE = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint unsigned CLK_PERIOD_PS  = 64'd4000;
  localparam longint unsigned PS_PER_MS      = 64'd1000000000;
  localparam longint unsigned HICCUP_MS      = 64'd130;
  // Least time, rounded up
  localparam longint unsigned HICCUP_CYC_DEF = (HICCUP_MS * PS_PER_MS + CLK_PERIOD_PS - 64'd1) / CLK_PERIOD_PS;
  localparam longint unsigned SYNC_FREQ_KHZ  = 64'd500;
  localparam longint unsigned SYNC_CYC_DEF   = PS_PER_MS / (SYNC_FREQ_KHZ * CLK_PERIOD_PS);
  localparam int              TOFF_W         = 16;
  localparam int              PER_W          = 16;

  // ----------------------------------------------------------------
  // Interleave phase: 22.5 degree steps
  // ----------------------------------------------------------------
  localparam int PHASE_STEP_CDEG = 2250;
  localparam int FULL_TURN_CDEG  = 36000;
  localparam int PHASE_STEPS     = FULL_TURN_CDEG / PHASE_STEP_CDEG;
  localparam int PHASE_W         = $clog2(PHASE_STEPS);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Code bits are the line levels of the two symbols after the fall
  typedef enum logic [1:0] {
    SEV_EMERGENCY = 2'h0,
    SEV_CRITICAL  = 2'h1,
    SEV_SEQUENCED = 2'h3
  } fpps_sev_t;

  typedef enum logic [1:0] {
    CORE_IDLE = 2'h0,
    CORE_RUN  = 2'h1,
    CORE_SHUT = 2'h2,
    CORE_OFF  = 2'h3
  } fpps_core_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_START = 3'h1,
    TX_BIT1  = 3'h2,
    TX_BIT0  = 3'h3,
    TX_HOLD  = 3'h4
  } fpps_tx_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_BIT1 = 2'h1,
    RX_BIT0 = 2'h2,
    RX_HOLD = 2'h3
  } fpps_rx_t;

  typedef struct packed {
    logic               fast;
    logic [PHASE_W-1:0] phase_step;
  } fpps_pwm_cfg_t;

  typedef struct packed {
    logic out_enable;
    logic ramp_down;
    logic hs_enable;
    logic ls_force;
  } fpps_drive_t;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Unused pattern 2 reads as critical
  function automatic fpps_sev_t sev_decode(input logic [1:0] bits);
    fpps_sev_t s;
    s = SEV_CRITICAL;
    if (bits == 2'h0) s = SEV_EMERGENCY;
    if (bits == 2'h3) s = SEV_SEQUENCED;
    return s;
  endfunction

  function automatic logic [PER_W-1:0] phase_delay(input logic [PHASE_W-1:0] step,
                                                   input logic [PER_W-1:0]   period);
    logic [31:0] prod;
    prod = 32'(step) * 32'(period);
    return PER_W'(prod >> PHASE_W);
  endfunction

endpackage

// ### fpps_sync2.sv
`timescale 1ns/1ps

module fpps_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // fpps_sync2

// ### fpps_pwm_phase.sv
`timescale 1ns/1ps

module fpps_pwm_phase #(
  parameter logic [fpps_pkg::PER_W-1:0] SYNC_CYC = fpps_pkg::PER_W'(fpps_pkg::SYNC_CYC_DEF)
) (
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  input  wire logic                    sync_fall,
  input  wire fpps_pkg::fpps_pwm_cfg_t pwm_cfg,
  output logic                         pwm_start
);

  logic [fpps_pkg::PER_W-1:0] cnt_q;
  logic [fpps_pkg::PER_W-1:0] period;
  logic [fpps_pkg::PER_W-1:0] dly;

  always_comb begin
    period = pwm_cfg.fast ? (SYNC_CYC >> 1) : SYNC_CYC;
    dly    = fpps_pkg::phase_delay(pwm_cfg.phase_step, period);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (sync_fall) begin
      cnt_q <= '0;
    end else if (cnt_q != SYNC_CYC - 1'h1) begin
      cnt_q <= cnt_q + 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pwm_start <= 1'h0;
    end else begin
      pwm_start <= !sync_fall && ((cnt_q == dly) || (pwm_cfg.fast && (cnt_q == dly + period)));
    end
  end

  chk_phase_start: assert property (@(posedge mclk) disable iff (!reset_n)
    pwm_start |-> ($past(cnt_q) == $past(dly)) || $past(pwm_cfg.fast))
    else $error("PWM start not at programmed phase");

endmodule // fpps_pwm_phase

// ### fpps_top.sv
// Overview of operation
// - Propagating fault pulls shared fault line low
// - Peer low line starts same-type shutdown
// - Severity carried in the two symbols after line's fall
// - Exactly three severities, sampled by receivers
// - Fault line changes only on sync falling edge
// - Propagation enabled per fault type
// - Non-propagating fault leaves line undriven
// - Hiccup retry every 130 ms, delay-independent
// - Sequenced shutdown honours delay and ramp
// - Switching frequency 500 kHz or 1 MHz
// - Lock to 500 kHz sync, falling edge
// - Frequency chosen per converter independently
// - PWM start delayed in 22.5 degree steps
// - Sequenced, critical, emergency switch behaviour
// - Latching fault holds off until cleared
`timescale 1ns/1ps

module fpps_top #(
  parameter int unsigned                HICCUP_CYC = int'(fpps_pkg::HICCUP_CYC_DEF),
  parameter logic [fpps_pkg::PER_W-1:0] SYNC_CYC   = fpps_pkg::PER_W'(fpps_pkg::SYNC_CYC_DEF)
) (
  input  wire logic                                           mclk,
  input  wire logic                                           reset_n,
  input  wire logic                                           sync_clock_line,
  input  wire logic                                           fault_line_i,
  output logic                                                fault_line_o,
  output logic                                                fault_line_oe,
  input  wire logic                 [fpps_pkg::FAULT_N-1:0]   fault_detect,
  input  wire fpps_pkg::fpps_sev_t  [fpps_pkg::FAULT_N-1:0]   fault_severity,
  input  wire logic                 [fpps_pkg::FAULT_N-1:0]   propagation_config,
  input  wire logic                 [fpps_pkg::FAULT_N-1:0]   latch_config,
  input  wire logic                                           turn_on,
  input  wire logic                                           status_clear,
  input  wire logic                 [fpps_pkg::TOFF_W-1:0]    toff_delay,
  input  wire logic                                           ramp_done,
  input  wire fpps_pkg::fpps_pwm_cfg_t                        pwm_cfg,
  output logic                      [fpps_pkg::FAULT_N-1:0]   protection_status,
  output fpps_pkg::fpps_drive_t                               drive,
  output logic                                                pwm_start
);

  localparam int HIC_W = $clog2(HICCUP_CYC + 1);
  localparam int FN    = fpps_pkg::FAULT_N;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fpps_pkg::fpps_core_t           state_q;
  fpps_pkg::fpps_core_t           state_d;
  fpps_pkg::fpps_sev_t            sev_q;
  fpps_pkg::fpps_sev_t            sev_d;
  fpps_pkg::fpps_sev_t            own_sev;
  logic                           own_q;
  logic                           latch_q;
  logic                           tx_req_q;
  logic [HIC_W-1:0]               hic_q;
  logic [fpps_pkg::TOFF_W-1:0]    dly_q;
  logic [FN-1:0]                  status_q;
  logic [2:0]                     core_sync;
  logic                           sclk_prev_q;
  logic                           rx_tgl_prev_q;
  logic                           sync_fall;
  logic                           peer_evt;
  logic                           peer_low;
  logic                           fault_any;
  logic                           prop_hit;
  logic                           latch_hit;
  logic                           shut_entry;
  logic                           restart_ok;
  logic                           link_rst_n;
  logic                           tx_req_m_q;
  logic                           tx_req_s_q;
  fpps_pkg::fpps_tx_t             tx_state_q;
  logic [1:0]                     tx_code_q;
  logic                           oe_q;
  logic                           line_s;
  logic                           line_prev_q;
  fpps_pkg::fpps_rx_t             rx_state_q;
  logic                           rx_b1_q;
  fpps_pkg::fpps_sev_t            rx_sev_q;
  logic                           rx_tgl_q;

  // ----------------------------------------------------------------
  // Crossings into mclk
  // ----------------------------------------------------------------
  fpps_sync2 #(.WIDTH(3)) u_sync_core (
    .clk   (mclk),
    .rst_n (reset_n),
    .d     ({sync_clock_line, fault_line_i, rx_tgl_q}),
    .q     (core_sync)
  );

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sclk_prev_q   <= 1'h0;
      rx_tgl_prev_q <= 1'h0;
    end else begin
      sclk_prev_q   <= core_sync[2];
      rx_tgl_prev_q <= core_sync[0];
    end
  end

  assign sync_fall = sclk_prev_q && !core_sync[2];
  assign peer_low  = !core_sync[1];
  assign peer_evt  = core_sync[0] ^ rx_tgl_prev_q;

  // ----------------------------------------------------------------
  // Fault decode
  // ----------------------------------------------------------------
  // Most severe active fault wins
  function automatic fpps_pkg::fpps_sev_t pick_sev(input logic [FN-1:0] hit,
                                                   input fpps_pkg::fpps_sev_t [FN-1:0] sev);
    fpps_pkg::fpps_sev_t s;
    s = fpps_pkg::SEV_SEQUENCED;
    for (int i = 0; i < FN; i++) begin
      if (hit[i] && (sev[i] == fpps_pkg::SEV_EMERGENCY)) s = fpps_pkg::SEV_EMERGENCY;
      else if (hit[i] && (sev[i] == fpps_pkg::SEV_CRITICAL) && (s != fpps_pkg::SEV_EMERGENCY)) s = sev[i];
    end
    return s;
  endfunction

  assign fault_any = |fault_detect;
  assign prop_hit  = |(fault_detect & propagation_config);
  assign latch_hit = |(fault_detect & latch_config);
  assign own_sev   = pick_sev(fault_detect, fault_severity);

  assign restart_ok = (hic_q == '0) && !fault_any &&
                      (own_q ? (!latch_q || (status_q == '0)) : !peer_low);

  // ----------------------------------------------------------------
  // Core state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sev_d   = sev_q;
    unique case (state_q)
      fpps_pkg::CORE_IDLE: begin
        if (turn_on && !fault_any && !peer_low) state_d = fpps_pkg::CORE_RUN;
      end
      fpps_pkg::CORE_RUN: begin
        if (!turn_on) begin
          state_d = fpps_pkg::CORE_IDLE;
        end else if (fault_any) begin
          state_d = fpps_pkg::CORE_SHUT;
          sev_d   = own_sev;
        end else if (peer_evt) begin
          state_d = fpps_pkg::CORE_SHUT;
          sev_d   = rx_sev_q;
        end
      end
      fpps_pkg::CORE_SHUT: begin
        if (sev_q != fpps_pkg::SEV_SEQUENCED) state_d = fpps_pkg::CORE_OFF;
        else if (drive.ramp_down && ramp_done) state_d = fpps_pkg::CORE_OFF;
      end
      fpps_pkg::CORE_OFF: begin
        if (!turn_on) state_d = fpps_pkg::CORE_IDLE;
        else if (restart_ok) state_d = fpps_pkg::CORE_RUN;
      end
    endcase
  end

  assign shut_entry = (state_q == fpps_pkg::CORE_RUN) && (state_d == fpps_pkg::CORE_SHUT);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= fpps_pkg::CORE_IDLE;
      sev_q   <= fpps_pkg::SEV_SEQUENCED;
    end else begin
      state_q <= state_d;
      sev_q   <= sev_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      own_q   <= 1'h0;
      latch_q <= 1'h0;
    end else if (shut_entry) begin
      own_q   <= fault_any;
      latch_q <= latch_hit;
    end else if (state_d == fpps_pkg::CORE_IDLE) begin
      latch_q <= 1'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tx_req_q <= 1'h0;
    end else if (shut_entry) begin
      tx_req_q <= fault_any && prop_hit;
    end else if ((state_d == fpps_pkg::CORE_RUN) || (state_d == fpps_pkg::CORE_IDLE)) begin
      tx_req_q <= 1'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hic_q <= '0;
    end else if (shut_entry) begin
      hic_q <= HIC_W'(HICCUP_CYC - 1);
    end else if (hic_q != '0) begin
      hic_q <= hic_q - 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dly_q <= '0;
    end else if (shut_entry) begin
      dly_q <= toff_delay;
    end else if (dly_q != '0) begin
      dly_q <= dly_q - 1'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      drive <= '0;
    end else begin
      drive.out_enable <= state_d == fpps_pkg::CORE_RUN;
      drive.hs_enable  <= (state_d == fpps_pkg::CORE_RUN) ||
                          ((state_d == fpps_pkg::CORE_SHUT) && (sev_d == fpps_pkg::SEV_SEQUENCED));
      drive.ls_force   <= ((state_d == fpps_pkg::CORE_SHUT) || (state_d == fpps_pkg::CORE_OFF)) &&
                          (sev_d == fpps_pkg::SEV_EMERGENCY);
      drive.ramp_down  <= (state_q == fpps_pkg::CORE_SHUT) && (state_d == fpps_pkg::CORE_SHUT) &&
                          (sev_q == fpps_pkg::SEV_SEQUENCED) && (dly_q == '0);
    end
  end

  // Sticky status, set beats clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~{FN{status_clear}}) | fault_detect;
    end
  end

  assign protection_status = status_q;

  // ----------------------------------------------------------------
  // PWM phase
  // ----------------------------------------------------------------
  // frequency select
  fpps_pwm_phase #(.SYNC_CYC(SYNC_CYC)) u_pwm (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .sync_fall (sync_fall),
    .pwm_cfg   (pwm_cfg),
    .pwm_start (pwm_start)
  );

  // ----------------------------------------------------------------
  // Link domain: transmit on falling sync edge
  // ----------------------------------------------------------------
  fpps_sync2 #(.WIDTH(2)) u_sync_link (
    .clk   (sync_clock_line),
    .rst_n (1'h1),
    .d     ({reset_n, fault_line_i}),
    .q     ({link_rst_n, line_s})
  );

  always_ff @(negedge sync_clock_line) begin
    if (!link_rst_n) begin
      tx_req_m_q <= 1'h0;
      tx_req_s_q <= 1'h0;
    end else begin
      tx_req_m_q <= tx_req_q;
      tx_req_s_q <= tx_req_m_q;
    end
  end

  always_ff @(negedge sync_clock_line) begin
    if (!link_rst_n) begin
      tx_state_q <= fpps_pkg::TX_IDLE;
      tx_code_q  <= 2'h3;
      oe_q       <= 1'h0;
    end else if (!tx_req_s_q) begin
      tx_state_q <= fpps_pkg::TX_IDLE;
      oe_q       <= 1'h0;
    end else begin
      unique case (tx_state_q)
        fpps_pkg::TX_IDLE: begin
          tx_state_q <= fpps_pkg::TX_START;
          tx_code_q  <= sev_q;
          oe_q       <= 1'h1;
        end
        fpps_pkg::TX_START: begin
          tx_state_q <= fpps_pkg::TX_BIT1;
          oe_q       <= !tx_code_q[1];
        end
        fpps_pkg::TX_BIT1: begin
          tx_state_q <= fpps_pkg::TX_BIT0;
          oe_q       <= !tx_code_q[0];
        end
        fpps_pkg::TX_BIT0, fpps_pkg::TX_HOLD: begin
          tx_state_q <= fpps_pkg::TX_HOLD;
          oe_q       <= 1'h1;
        end
        default: begin
          tx_state_q <= fpps_pkg::TX_IDLE;
          oe_q       <= 1'h0;
        end
      endcase
    end
  end

  assign fault_line_o  = 1'h0;
  assign fault_line_oe = oe_q;

  // ----------------------------------------------------------------
  // Link domain: receive on rising sync edge
  // ----------------------------------------------------------------
  // sample three severities
  always_ff @(posedge sync_clock_line) begin
    if (!link_rst_n) begin
      rx_state_q  <= fpps_pkg::RX_IDLE;
      line_prev_q <= 1'h1;
      rx_b1_q     <= 1'h1;
      rx_sev_q    <= fpps_pkg::SEV_SEQUENCED;
      rx_tgl_q    <= 1'h0;
    end else begin
      line_prev_q <= line_s;
      unique case (rx_state_q)
        fpps_pkg::RX_IDLE: begin
          if (line_prev_q && !line_s && (tx_state_q == fpps_pkg::TX_IDLE)) rx_state_q <= fpps_pkg::RX_BIT1;
        end
        fpps_pkg::RX_BIT1: begin
          rx_b1_q    <= line_s;
          rx_state_q <= fpps_pkg::RX_BIT0;
        end
        fpps_pkg::RX_BIT0: begin
          rx_sev_q   <= fpps_pkg::sev_decode({rx_b1_q, line_s});
          rx_tgl_q   <= !rx_tgl_q;
          rx_state_q <= fpps_pkg::RX_HOLD;
        end
        fpps_pkg::RX_HOLD: begin
          if (line_s) rx_state_q <= fpps_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_prop_drive: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_RUN && turn_on && prop_hit) |=> tx_req_q && state_q == fpps_pkg::CORE_SHUT)
    else $error("Propagating fault did not request line drive");
  chk_noprop_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_RUN && turn_on && fault_any && !prop_hit) |=> !tx_req_q)
    else $error("Non-propagating fault drove the line");
  chk_peer_type: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_RUN && turn_on && !fault_any && peer_evt) |=> sev_q == $past(rx_sev_q))
    else $error("Peer shutdown used wrong turn-off type");
  chk_emerg_switch: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_SHUT && sev_q == fpps_pkg::SEV_EMERGENCY) |-> drive.ls_force && !drive.hs_enable)
    else $error("Emergency turn-off switch state wrong");
  chk_crit_switch: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_SHUT && sev_q == fpps_pkg::SEV_CRITICAL) |-> !drive.ls_force && !drive.hs_enable)
    else $error("Critical turn-off switch state wrong");
  chk_hiccup_min: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_OFF && state_d == fpps_pkg::CORE_RUN) |-> hic_q == '0)
    else $error("Restart before hiccup interval");
  chk_latch_hold: assert property (@(posedge mclk) disable iff (!reset_n)
    (state_q == fpps_pkg::CORE_OFF && own_q && latch_q && status_q != '0) |=> state_q != fpps_pkg::CORE_RUN)
    else $error("Latched fault restarted without clear");
  chk_seq_delay: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(drive.ramp_down) |-> $past(dly_q) == '0 && sev_q == fpps_pkg::SEV_SEQUENCED)
    else $error("Ramp down began before turn-off delay");
  chk_release_run: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(tx_req_q) |-> state_q == fpps_pkg::CORE_RUN || state_q == fpps_pkg::CORE_IDLE)
    else $error("Fault line released without restart");
  chk_code_symbol: assert property (@(negedge sync_clock_line) disable iff (!link_rst_n)
    (tx_req_s_q && tx_state_q == fpps_pkg::TX_START) |=> oe_q == !tx_code_q[1] ##1 oe_q == !tx_code_q[0])
    else $error("Severity symbols wrong on fault line");

  cov_seq_shut: cover property (@(posedge mclk) disable iff (!reset_n) $rose(drive.ramp_down));
  cov_emerg:    cover property (@(posedge mclk) disable iff (!reset_n) $rose(drive.ls_force));
  cov_peer:     cover property (@(posedge mclk) disable iff (!reset_n) peer_evt && state_q == fpps_pkg::CORE_RUN);
  cov_restart:  cover property (@(posedge mclk) disable iff (!reset_n)
    state_q == fpps_pkg::CORE_OFF && state_d == fpps_pkg::CORE_RUN);

endmodule // fpps_top

// ### fpps_mgr_model.sv
`timescale 1ns/1ps

module fpps_mgr_model (
  output logic             sync_clock_line,
  output logic             peer_oe,
  input  wire logic        send,
  input  wire logic [1:0]  code
);
  logic [1:0] step_q;

  initial begin
    sync_clock_line = 1'b0;
    peer_oe         = 1'b0;
    step_q          = 2'h0;
    // Offset keeps sync edges off the mclk grid
    #13.7;
    forever #32 sync_clock_line = ~sync_clock_line;
  end

  // front end and crowbar left unconfigured

  always @(negedge sync_clock_line) begin
    if (!send) begin
      peer_oe <= 1'b0;
      step_q  <= 2'h0;
    end else begin
      step_q  <= (step_q == 2'h3) ? 2'h3 : step_q + 2'h1;
      peer_oe <= (step_q == 2'h1) ? !code[1] : (step_q == 2'h2) ? !code[0] : 1'b1;
    end
  end
endmodule // fpps_mgr_model

// ### fpps_top_tb.sv
`timescale 1ns/1ps

module fpps_top_tb;
  logic                      mclk;
  logic                      reset_n;
  logic                      sync_clock_line;
  logic                      peer_oe;
  logic                      send;
  logic [1:0]                code;
  logic                      fault_line_oe;
  logic [5:0]                fault_detect;
  fpps_pkg::fpps_sev_t [5:0] sev;
  logic [5:0]                prop;
  logic [5:0]                latch;
  logic                      clr;
  logic [5:0]                status;
  logic                      turn_on;
  fpps_pkg::fpps_pwm_cfg_t   pwm_cfg;
  fpps_pkg::fpps_drive_t     drive;
  logic                      pwm_start;
  int                        n_errors;
  int                        checked;
  int                        off_n;

  fpps_top #(.HICCUP_CYC(200), .SYNC_CYC(16'h0010)) i_dut (
    .mclk(mclk), .reset_n(reset_n), .sync_clock_line(sync_clock_line),
    .fault_line_i(!(fault_line_oe | peer_oe)), .fault_line_o(), .fault_line_oe(fault_line_oe),
    .fault_detect(fault_detect), .fault_severity(sev), .propagation_config(prop),
    .latch_config(latch), .turn_on(turn_on), .status_clear(clr), .toff_delay(16'h0020),
    .ramp_done(drive.ramp_down), .pwm_cfg(pwm_cfg), .protection_status(status), .drive(drive),
    .pwm_start(pwm_start));

  fpps_mgr_model i_mgr (.sync_clock_line(sync_clock_line), .peer_oe(peer_oe), .send(send), .code(code));

  always #2 mclk = ~mclk;
  always @(posedge mclk) off_n <= drive.out_enable ? off_n : off_n + 1;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask

  task close_out;
    $display("counts: %0d checked, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bounded wait: 0 line, 1 out_enable, 3 pwm_start
  task wait_sig(input int sel, input logic v);
    logic s;
    for (int i = 0; i < 2000; i++) begin
      s = (sel == 0) ? fault_line_oe : (sel == 1) ? drive.out_enable : pwm_start;
      if (s === v) return;
      @(posedge mclk); #1;
    end
    n_errors++;
    $display("mismatch wait%0d exp %h seen %h", sel, v, s);
    close_out;
  endtask

  task sev_case(input fpps_pkg::fpps_sev_t s);
    sev = {6{s}};
    prop = 6'h3f;
    off_n = 0;
    fault_detect = 6'h04;
    @(posedge mclk); #1;
    fault_detect = 6'h00;
    @(posedge mclk); #1;
    check("ls_force", drive.ls_force, s == fpps_pkg::SEV_EMERGENCY);
    check("hs_enable", drive.hs_enable, s == fpps_pkg::SEV_SEQUENCED);
    wait_sig(0, 1);
    @(negedge sync_clock_line); #1;
    check("bit1", fault_line_oe, !s[1]);
    @(negedge sync_clock_line); #1;
    check("bit0", fault_line_oe, !s[0]);
    @(negedge sync_clock_line); #1;
    check("hold", fault_line_oe, 1);
    wait_sig(1, 1);
    check("off_time", off_n >= 200 && off_n <= 208, 1);
    wait_sig(0, 0);
    $display("test severity %0d done", s);
  endtask

  task nonprop;
    logic low;
    prop = 6'h37;
    low = 1'b0;
    fault_detect = 6'h08;
    @(posedge mclk); #1;
    fault_detect = 6'h00;
    for (int i = 0; i < 260; i++) begin
      low |= fault_line_oe;
      @(posedge mclk); #1;
    end
    check("line_idle", low, 0);
    check("restarted", drive.out_enable, 1);
    $display("test nonprop done");
  endtask

  task latch_case;
    prop = 6'h00;
    latch = 6'h02;
    fault_detect = 6'h02;
    @(posedge mclk); #1;
    fault_detect = 6'h00;
    repeat (260) @(posedge mclk);
    #1;
    check("latched_off", drive.out_enable, 0);
    check("status_set", status, 6'h0e);
    clr = 1'b1;
    @(posedge mclk); #1;
    clr = 1'b0;
    latch = 6'h00;
    check("status_clr", status, 6'h00);
    wait_sig(1, 1);
    $display("test latch done");
  endtask

  task peer_case(input logic [1:0] c);
    code = c;
    send = 1'b1;
    wait_sig(1, 0);
    check("peer_ls", drive.ls_force, c == 2'h0);
    send = 1'b0;
    wait_sig(1, 1);
    $display("test peer %0d done", c);
  endtask

  task pwm_case(input logic f, input int gap, input int d);
    int n;
    pwm_cfg = '{fast: f, phase_step: 4'h8};
    wait_sig(3, 1);
    wait_sig(3, 0);
    wait_sig(3, 1);
    n = 0;
    @(posedge mclk); #1;
    while (pwm_start !== 1'b1 && n < 40) begin
      n++;
      @(posedge mclk); #1;
    end
    check("pwm_gap", n + 1, gap);
    @(negedge sync_clock_line);
    n = 0;
    do begin
      @(posedge mclk); #1;
      n++;
    end while (pwm_start !== 1'b1 && n < 40);
    check("pwm_phase", n >= d + 2 && n <= d + 5, 1);
    $display("test pwm %0d done", f);
  endtask

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    send = 1'b0;
    code = 2'h0;
    fault_detect = 6'h00;
    sev = {6{fpps_pkg::SEV_SEQUENCED}};
    prop = 6'h00;
    latch = 6'h00;
    clr = 1'b0;
    turn_on = 1'b0;
    pwm_cfg = '0;
    n_errors = 0;
    checked = 0;
    off_n = 0;
    // Long enough for the sync domain too
    repeat (64) @(posedge mclk); #1;
    reset_n = 1'b1;
    @(posedge mclk); #1;
    turn_on = 1'b1;
    wait_sig(1, 1);
    sev_case(fpps_pkg::SEV_EMERGENCY);
    sev_case(fpps_pkg::SEV_CRITICAL);
    sev_case(fpps_pkg::SEV_SEQUENCED);
    nonprop;
    latch_case;
    peer_case(2'h0);
    peer_case(2'h1);
    peer_case(2'h3);
    pwm_case(1'b0, 16, 8);
    pwm_case(1'b1, 8, 4);
    close_out;
  end
endmodule // fpps_top_tb
